/* gpcn_port.sv */
// shared gpio port with peripheral override, open drain, analog and change notify
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module gpcn_port #(
    parameter int unsigned      PORT_W      = 16,      // pins in this port
    parameter logic [15:0]      IMPL_MASK   = 16'hffff, // implemented pins
    parameter logic [15:0]      ANALOG_MASK = 16'h00ff, // pins with analog function
    parameter int unsigned      CN_W        = 21,      // change notify pins
    parameter int unsigned      REMAP_W     = 26       // remappable pins
) (
    input  wire logic                          clk,          // system clock 250 MHz
    input  wire logic                          rst_n,        // async reset, active low
    input  wire logic [gpcn_pkg::ADDR_W-1:0]   addr,         // register byte address
    input  wire logic [gpcn_pkg::DATA_W-1:0]   wdata,        // write data
    input  wire logic                          wr,           // write strobe
    input  wire logic                          rd,           // read strobe
    output logic      [gpcn_pkg::DATA_W-1:0]   rdata,        // read data, cycle after rd
    input  wire logic [PORT_W-1:0]             pad_in,       // pin levels
    output logic      [PORT_W-1:0]             pad_out,      // pin output value
    output logic      [PORT_W-1:0]             pad_oe,       // pin driver enable
    input  wire logic [PORT_W-1:0]             periph_drive, // peripheral enabled, driving
    input  wire logic [PORT_W-1:0]             periph_out,   // peripheral output value
    output logic      [PORT_W-1:0]             periph_in,    // pin level to peripheral
    output logic      [PORT_W-1:0]             adc_conn,     // pin routed to converter
    input  wire logic [CN_W-1:0]               change_notify_input, // change pins
    output logic      [CN_W-1:0]               pullup_en,    // weak pull-up enables
    output logic                               change_irq    // change interrupt pulse
);
    localparam logic [PORT_W-1:0] IMPL = IMPL_MASK[PORT_W-1:0]; // valid pins
    localparam logic [PORT_W-1:0] ANAM = ANALOG_MASK[PORT_W-1:0] & IMPL; // analog pins
    localparam int unsigned       CN_HI_W = CN_W - gpcn_pkg::CN_LO_W; // high enable bits

    // registers
    logic [PORT_W-1:0]  dir_q;          // direction_reg
    logic [PORT_W-1:0]  lat_q;          // output_latch_reg
    logic [PORT_W-1:0]  odc_q;          // open_drain_ctrl_reg
    logic [PORT_W-1:0]  ana_q;          // analog_pin_config_reg, 0 = analog
    logic [CN_W-1:0]    cnen_q;         // change_irq_enable lo and hi
    logic [CN_W-1:0]    pu_q;           // pullup_enable lo and hi
    logic [PORT_W-1:0]  pin_sync;       // synchronised pin levels
    logic [CN_W-1:0]    cn_sync;        // synchronised change pins
    logic [CN_W-1:0]    cn_prev_q;      // previous change sample
    logic               cn_armed_q;     // previous sample is valid
    logic [PORT_W-1:0]  remap_ok;       // pins a peripheral may take
    logic [PORT_W-1:0]  own_periph;     // peripheral owns the driver
    logic [PORT_W-1:0]  port_drive;     // port logic drives the pin
    logic [PORT_W-1:0]  analog_mode;    // pin in analog mode
    logic [PORT_W-1:0]  pin_read;       // pin value as software sees it
    logic [PORT_W-1:0]  drv_val;        // selected output value
    logic [PORT_W-1:0]  drv_en;         // selected driver enable
    logic [PORT_W-1:0]  pad_out_d;      // next pad_out
    logic [PORT_W-1:0]  pad_oe_d;       // next pad_oe
    logic [CN_W-1:0]    cn_event;       // enabled mismatches this cycle
    logic [gpcn_pkg::DATA_W-1:0] rdata_d; // next read data
    logic [PORT_W-1:0]  wval;           // write data cut to the port

    assign wval = wdata[PORT_W-1:0] & IMPL; // only implemented bits store

    // pin and change input synchronisers
    gpcn_sync3 #(.W(PORT_W)) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pad_in),
        .stable_q (pin_sync)
    );

    gpcn_sync3 #(.W(CN_W)) u_cn_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (change_notify_input),
        .stable_q (cn_sync)
    );

    // direction register, inputs after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= gpcn_pkg::RST_DIR[PORT_W-1:0] & IMPL;
        end else if (wr && addr == gpcn_pkg::OFF_DIR) begin
            dir_q <= wval;
        end
    end

    // output latch, written through latch or pin register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_q <= gpcn_pkg::RST_LAT[PORT_W-1:0];
        end else if (wr && (addr == gpcn_pkg::OFF_LAT || addr == gpcn_pkg::OFF_PIN)) begin
            lat_q <= wval;
        end
    end

    // open-drain control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            odc_q <= gpcn_pkg::RST_ODC[PORT_W-1:0];
        end else if (wr && addr == gpcn_pkg::OFF_ODC) begin
            odc_q <= wval;
        end
    end

    // analog configuration, zero selects analog
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_q <= gpcn_pkg::RST_ANA[PORT_W-1:0];
        end else if (wr && addr == gpcn_pkg::OFF_ANA) begin
            ana_q <= wdata[PORT_W-1:0] & ANAM;
        end
    end

    // change enables, split over two registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnen_q <= {CN_W{1'b0}};
        end else if (wr && addr == gpcn_pkg::OFF_CNEN_LO) begin
            cnen_q[gpcn_pkg::CN_LO_W-1:0] <= wdata;
        end else if (wr && addr == gpcn_pkg::OFF_CNEN_HI) begin
            cnen_q[CN_W-1:gpcn_pkg::CN_LO_W] <= wdata[CN_HI_W-1:0];
        end
    end

    // pull-up enables, split over two registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_q <= {CN_W{1'b0}};
        end else if (wr && addr == gpcn_pkg::OFF_PU_LO) begin
            pu_q[gpcn_pkg::CN_LO_W-1:0] <= wdata;
        end else if (wr && addr == gpcn_pkg::OFF_PU_HI) begin
            pu_q[CN_W-1:gpcn_pkg::CN_LO_W] <= wdata[CN_HI_W-1:0];
        end
    end

    assign pullup_en = pu_q;

    // per-pin ownership and driver selection
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            // only remappable pins can be taken by a peripheral
            assign remap_ok[gi]    = (gi < REMAP_W);
            // idle or input-only peripheral leaves the pin to the port
            assign own_periph[gi]  = periph_drive[gi] & remap_ok[gi] & IMPL[gi];
            assign port_drive[gi]  = ~own_periph[gi] & ~dir_q[gi] & IMPL[gi];
            assign drv_val[gi]     = own_periph[gi] ? periph_out[gi] : lat_q[gi];
            assign drv_en[gi]      = own_periph[gi] | port_drive[gi];
            // open drain drives low only, a high floats
            assign pad_out_d[gi]   = odc_q[gi] ? 1'b0 : drv_val[gi];
            assign pad_oe_d[gi]    = drv_en[gi] & ~(odc_q[gi] & drv_val[gi]);
            assign analog_mode[gi] = ANAM[gi] & ~ana_q[gi];
            // converter sees the pin only in analog mode
            assign adc_conn[gi]    = analog_mode[gi];
            assign pin_read[gi]    = pin_sync[gi] & ~analog_mode[gi] & IMPL[gi];
            // block own port output from feeding the peripheral
            assign periph_in[gi]   = pin_sync[gi] & ~port_drive[gi] & IMPL[gi];
        end
    endgenerate

    // pad outputs from flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= '0;
            pad_oe  <= '0;
        end else begin
            pad_out <= pad_out_d;
            pad_oe  <= pad_oe_d;
        end
    end

    // change detection against the previous sample
    assign cn_event = (cn_sync ^ cn_prev_q) & cnen_q & {CN_W{cn_armed_q}};

    // the reference only moves with the clock, so a change made while
    // clocks are stopped is still caught, as a mismatch after the fourth edge once it clears the synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cn_prev_q  <= {CN_W{1'b0}};
            cn_armed_q <= 1'b0;
        end else begin
            cn_prev_q  <= cn_sync;
            cn_armed_q <= 1'b1;
        end
    end

    // shared change interrupt, one pulse per cycle with any event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            change_irq <= 1'b0;
        end else begin
            change_irq <= |cn_event;
        end
    end

    // read decode, unmapped reads zero
    always_comb begin
        rdata_d = '0;
        unique case (addr)
            gpcn_pkg::OFF_DIR:     rdata_d[PORT_W-1:0] = dir_q & IMPL;
            gpcn_pkg::OFF_LAT:     rdata_d[PORT_W-1:0] = lat_q;
            gpcn_pkg::OFF_PIN:     rdata_d[PORT_W-1:0] = pin_read;
            gpcn_pkg::OFF_ODC:     rdata_d[PORT_W-1:0] = odc_q;
            gpcn_pkg::OFF_ANA:     rdata_d[PORT_W-1:0] = ana_q;
            gpcn_pkg::OFF_CNEN_LO: rdata_d = cnen_q[gpcn_pkg::CN_LO_W-1:0];
            gpcn_pkg::OFF_CNEN_HI: rdata_d[CN_HI_W-1:0] = cnen_q[CN_W-1:gpcn_pkg::CN_LO_W];
            gpcn_pkg::OFF_PU_LO:   rdata_d = pu_q[gpcn_pkg::CN_LO_W-1:0];
            gpcn_pkg::OFF_PU_HI:   rdata_d[CN_HI_W-1:0] = pu_q[CN_W-1:gpcn_pkg::CN_LO_W];
            default:               rdata_d = '0;           // unmapped
        endcase
    end

    // read data held only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= rdata_d;
        end else begin
            rdata <= '0;
        end
    end

    // checks

    // taken pin: enable follows the peripheral
    a_periph_owns_pin: assert property (@(posedge clk) disable iff (!rst_n)
        own_periph[0] |=> pad_oe[0] == ~($past(odc_q[0]) & $past(periph_out[0])))
        else $error("peripheral drive not on pad");

    // taken pin still reads back
    a_periph_pin_read: assert property (@(posedge clk) disable iff (!rst_n)
        own_periph[0] |-> periph_in[0] == pin_sync[0])
        else $error("taken pin not readable");

    // idle peripheral leaves the latch on the pad
    a_idle_periph_port: assert property (@(posedge clk) disable iff (!rst_n)
        (!periph_drive[0] && !dir_q[0] && !odc_q[0])
        |=> pad_oe[0] && pad_out[0] == $past(lat_q[0]))
        else $error("port not driving idle pin");

    // own output kept off the peripheral input
    a_no_loop_through: assert property (@(posedge clk) disable iff (!rst_n)
        port_drive[0] |-> !periph_in[0])
        else $error("port output looped to peripheral");

    // input pin is not driven
    a_input_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (dir_q[0] && !periph_drive[0]) |=> !pad_oe[0])
        else $error("input pin driven");

    // direction write lands
    a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_DIR) |=> dir_q == $past(wval))
        else $error("direction write lost");

    // released reset leaves every pin an input
    a_reset_inputs: assert property (@(posedge clk)
        $rose(rst_n) |-> dir_q == (gpcn_pkg::RST_DIR[PORT_W-1:0] & IMPL) && pad_oe == '0)
        else $error("pins not inputs after reset");

    // latch reads back what was written
    a_latch_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_LAT) ##[1:2] (rd && addr == gpcn_pkg::OFF_LAT && !wr)
        |=> rdata[PORT_W-1:0] == $past(lat_q))
        else $error("latch read mismatch");

    // read data only in the cycle after a strobe
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == '0)
        else $error("read data outside its cycle");

    // pin register write goes to the latch
    a_pin_write_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_PIN) |=> lat_q == $past(wval))
        else $error("pin write missed latch");

    // missing pins read zero
    a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && (addr == gpcn_pkg::OFF_DIR || addr == gpcn_pkg::OFF_LAT
            || addr == gpcn_pkg::OFF_PIN)) |=> (rdata[PORT_W-1:0] & ~IMPL) == '0)
        else $error("unimplemented bit read high");

    // analog pins read low
    a_analog_reads_low: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && addr == gpcn_pkg::OFF_PIN) |=> (rdata[PORT_W-1:0] & $past(analog_mode)) == '0)
        else $error("analog pin read high");

    // open drain never drives high
    a_open_drain_high: assert property (@(posedge clk) disable iff (!rst_n)
        (odc_q[0] && drv_val[0]) |=> !pad_oe[0] && !pad_out[0])
        else $error("open drain drove high");

    // open-drain write lands
    a_odc_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_ODC) |=> odc_q == $past(wval))
        else $error("open drain write lost");

    // analog config keeps only analog pins
    a_analog_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_ANA) |=> ana_q == ($past(wdata[PORT_W-1:0]) & ANAM))
        else $error("analog config write lost");

    // digital pin not routed to converter
    a_digital_no_adc: assert property (@(posedge clk) disable iff (!rst_n)
        (ana_q[0] || !ANAM[0]) |-> !adc_conn[0])
        else $error("digital pin fed converter");

    // enabled mismatch raises the pulse
    a_change_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (cn_armed_q && |((cn_sync ^ cn_prev_q) & cnen_q)) |=> change_irq)
        else $error("change not flagged");

    // no change, no pulse
    a_no_spurious_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (cn_sync == cn_prev_q) |=> !change_irq)
        else $error("spurious change irq");

    // high change enables land in the upper bits
    a_cn_hi_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_CNEN_HI)
        |=> cnen_q[CN_W-1:gpcn_pkg::CN_LO_W] == $past(wdata[CN_HI_W-1:0]))
        else $error("change enable write lost");

    // low pull-up write reaches the pull-up pins
    a_pullup_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == gpcn_pkg::OFF_PU_LO)
        |=> pullup_en[gpcn_pkg::CN_LO_W-1:0] == $past(wdata))
        else $error("pull-up write lost");
endmodule : gpcn_port

/* gpcn_pkg.sv */
// constants shared by the gpio port with change notification
package gpcn_pkg;
    localparam int unsigned ADDR_W      = 8;          // register address width
    localparam int unsigned DATA_W      = 16;         // register data width
    localparam int unsigned CN_LO_W     = 16;         // change bits in the low enable reg
    // register byte offsets
    localparam logic [7:0]  OFF_DIR     = 8'h00;      // direction_reg
    localparam logic [7:0]  OFF_LAT     = 8'h04;      // output_latch_reg
    localparam logic [7:0]  OFF_PIN     = 8'h08;      // pin_value_reg
    localparam logic [7:0]  OFF_ODC     = 8'h0c;      // open_drain_ctrl_reg
    localparam logic [7:0]  OFF_ANA     = 8'h10;      // analog_pin_config_reg
    localparam logic [7:0]  OFF_CNEN_LO = 8'h14;      // change_irq_enable_lo
    localparam logic [7:0]  OFF_CNEN_HI = 8'h18;      // change_irq_enable_hi
    localparam logic [7:0]  OFF_PU_LO   = 8'h1c;      // pullup_enable_lo
    localparam logic [7:0]  OFF_PU_HI   = 8'h20;      // pullup_enable_hi
    // values after reset
    localparam logic [15:0] RST_DIR     = 16'hffff;   // every pin an input
    localparam logic [15:0] RST_LAT     = 16'h0000;   // latch cleared
    localparam logic [15:0] RST_ODC     = 16'h0000;   // push-pull
    localparam logic [15:0] RST_ANA     = 16'h0000;   // analog pins start analog
    localparam logic [15:0] RST_CNEN    = 16'h0000;   // no change interrupts
    localparam logic [15:0] RST_PU      = 16'h0000;   // pull-ups off
    // read lag of the register port in cycles
    localparam int unsigned RD_LAG      = 1;          // data one cycle after strobe
endpackage : gpcn_pkg

/* gpcn_sync3.sv */
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module gpcn_sync3 #(
    parameter int unsigned W = 1                       // number of bits
) (
    input  wire logic         clk,                     // system clock
    input  wire logic         rst_n,                   // async reset, active low
    input  wire logic [W-1:0] async_in,                // level from outside the domain
    output logic      [W-1:0] stable_q                 // filtered synchronous level
);
    logic [W-1:0] s1_q;                                // first stage, read only by s2
    logic [W-1:0] s2_q;                                // second stage
    logic [W-1:0] s3_q;                                // third stage

    // shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level per bit once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_q <= '0;
        end else begin
            stable_q <= (s2_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
        end
    end
endmodule : gpcn_sync3

/* gpcn_pins.sv */
// behavioural model of the board pins around the port
`timescale 1ns/1ns
module gpcn_pins (
    input  wire logic        clk,       // system clock
    input  wire logic [15:0] pad_out,   // value from the port
    input  wire logic [15:0] pad_oe,    // port drives pin
    input  wire logic [15:0] ext_val,   // outside driver value
    input  wire logic [15:0] ext_drv,   // outside driver active
    input  wire logic [15:0] pull,      // weak pull-up on
    output logic      [15:0] pad_level  // resolved pin level
);
    logic [15:0] float_q;               // level of a floating pin
    // a floating pin flips every cycle so the agreement filter never accepts it and the last settled level keeps reading
    initial begin
        float_q = 16'h5a5a;
        forever @(posedge clk) float_q <= ~float_q;
    end
    // port driver first, then outside driver, then pull-up, else floating
    assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
                     | (~pad_oe & ~ext_drv & (pull | float_q));
endmodule : gpcn_pins

/* test_gpcn_port.sv */
// self-checking bench for the shared gpio port
`timescale 1ns/1ns
module test_gpcn_port;
    localparam logic [15:0] IMPL  = 16'h7fff;   // top pin left out
    localparam logic [15:0] ANA_M = 16'h00ff;   // pins with analog use
    logic        clk   = 1'b0;                  // system clock
    logic        rst_n = 1'b0;                  // reset, active low
    logic [7:0]  addr  = 8'h00;                 // register address
    logic [15:0] wdata = 16'h0000;              // write data
    logic        wr    = 1'b0;                  // write strobe
    logic        rd    = 1'b0;                  // read strobe
    logic [15:0] rdata, pad_level, pad_out, pad_oe, periph_in, adc_conn; // design side
    logic [15:0] pdrv = 16'h0, pout = 16'h0, ext_val = 16'h0, ext_drv = 16'h0; // far side
    logic [20:0] cn_in = 21'h0, pullup_en;      // change pins, pull-ups
    logic        change_irq;                    // change pulse
    logic [15:0] m_dir, m_lat, m_odc, m_ana, a, d, mk; // model registers, scratch
    logic [20:0] m_cnen, m_pu;                  // model enables
    logic [31:0] seed = 32'h2e3d41a0;           // random state
    int          n_fail = 0, n_compared = 0;    // counters
    int          bits [4] = '{0, 15, 16, 20};   // change pins tried
    logic [7:0]  offs [10] = '{gpcn_pkg::OFF_DIR, gpcn_pkg::OFF_LAT, gpcn_pkg::OFF_PIN,
        gpcn_pkg::OFF_ODC, gpcn_pkg::OFF_ANA, gpcn_pkg::OFF_CNEN_LO, gpcn_pkg::OFF_CNEN_HI,
        gpcn_pkg::OFF_PU_LO, gpcn_pkg::OFF_PU_HI, 8'h24};   // last one unmapped

    gpcn_port #(.IMPL_MASK(IMPL), .ANALOG_MASK(ANA_M)) gpcn_port_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe),
        .periph_drive(pdrv), .periph_out(pout), .periph_in(periph_in), .adc_conn(adc_conn),
        .change_notify_input(cn_in), .pullup_en(pullup_en), .change_irq(change_irq));
    gpcn_pins gpcn_pins_i (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
        .ext_drv(ext_drv), .pull(pullup_en[15:0]), .pad_level(pad_level));

    // clock at 4 ns
    initial begin
        forever #2 clk = ~clk;
    end
    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // sixteen random bits
    function automatic logic [15:0] r16();
        return 16'(rnd());
    endfunction : r16
    // value each pin should carry, peripheral first
    function automatic logic [15:0] src_e();
        return (pdrv & pout) | (~pdrv & m_lat);
    endfunction : src_e
    function automatic logic [15:0] oe_e();
        return IMPL & (pdrv | ~m_dir) & ~(m_odc & src_e());
    endfunction : oe_e
    function automatic logic [15:0] lvl_e();
        return (oe_e() & src_e()) | (~oe_e() & ext_val);
    endfunction : lvl_e
    // expected read data per address
    function automatic logic [15:0] exp_rd(logic [7:0] x);
        case (x)
            gpcn_pkg::OFF_DIR:     return m_dir;
            gpcn_pkg::OFF_LAT:     return m_lat;
            gpcn_pkg::OFF_PIN:     return lvl_e() & IMPL & (m_ana | ~ANA_M);
            gpcn_pkg::OFF_ODC:     return m_odc;
            gpcn_pkg::OFF_ANA:     return m_ana;
            gpcn_pkg::OFF_CNEN_LO: return m_cnen[15:0];
            gpcn_pkg::OFF_CNEN_HI: return {11'h000, m_cnen[20:16]};
            gpcn_pkg::OFF_PU_LO:   return m_pu[15:0];
            gpcn_pkg::OFF_PU_HI:   return {11'h000, m_pu[20:16]};
            default:               return 16'h0000;
        endcase
    endfunction : exp_rd
    // compare and count
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one write cycle, model follows
    task automatic wr_reg(logic [7:0] x, logic [15:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= x;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        case (x)
            gpcn_pkg::OFF_DIR:     m_dir = v & IMPL;
            gpcn_pkg::OFF_LAT,
            gpcn_pkg::OFF_PIN:     m_lat = v & IMPL;
            gpcn_pkg::OFF_ODC:     m_odc = v & IMPL;
            gpcn_pkg::OFF_ANA:     m_ana = v & IMPL & ANA_M;
            gpcn_pkg::OFF_CNEN_LO: m_cnen[15:0] = v;
            gpcn_pkg::OFF_CNEN_HI: m_cnen[20:16] = v[4:0];
            gpcn_pkg::OFF_PU_LO:   m_pu[15:0] = v;
            gpcn_pkg::OFF_PU_HI:   m_pu[20:16] = v[4:0];
            default:               ;
        endcase
    endtask : wr_reg
    // one read cycle, data the cycle after, zero after that
    task automatic rd_chk(logic [7:0] x);
        logic [15:0] e;
        e = exp_rd(x);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= x;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
        @(posedge clk);
        #1 chk("rdata idle", rdata, 16'h0000);
    endtask : rd_chk
    // count change pulses over a window longer than the sync path
    task automatic cnt_irq(int e);
        int c;
        c = 0;
        repeat (14) begin
            @(posedge clk);
            #1 if (change_irq === 1'b1) c++;
        end
        chk("irq pulses", c, e);
    endtask : cnt_irq
    // reset for two cycles, model back to reset values
    task automatic do_reset();
        rst_n  <= 1'b0;
        m_dir  = IMPL;
        m_lat  = 16'h0;
        m_odc  = 16'h0;
        m_ana  = 16'h0;
        m_cnen = 21'h0;
        m_pu   = 21'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // verdict
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // hang guard, far beyond the few hundred cycles of the tests
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    // main sequence
    initial begin
        do_reset();
        foreach (offs[i]) rd_chk(offs[i]);
        chk("adc_conn", adc_conn, ANA_M & IMPL);
        chk("pad_oe", pad_oe, 16'h0000);
        $display("test reset done");
        wr_reg(gpcn_pkg::OFF_LAT, r16());
        rd_chk(gpcn_pkg::OFF_LAT);
        wr_reg(gpcn_pkg::OFF_PIN, r16());
        rd_chk(gpcn_pkg::OFF_LAT);
        // random traffic, pin register writes read back from the latch
        repeat (12) begin
            a = offs[rnd() % 10];
            d = r16() & ((a == gpcn_pkg::OFF_ODC || a == gpcn_pkg::OFF_ANA) ? IMPL : 16'hffff);
            wr_reg(a, d);
            rd_chk((a == gpcn_pkg::OFF_PIN) ? gpcn_pkg::OFF_LAT : a);
        end
        $display("test registers done");
        // pin ownership, open drain, analog reads, loop-through
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            pdrv <= (k % 2) ? r16() : 16'h0;
            pout <= r16();
            wr_reg(gpcn_pkg::OFF_ANA, r16() & IMPL);
            wr_reg(gpcn_pkg::OFF_ODC, (k > 2) ? r16() & IMPL : 16'h0);
            wr_reg(gpcn_pkg::OFF_DIR, r16() | (ANA_M & ~m_ana));
            wr_reg(gpcn_pkg::OFF_LAT, r16());
            wr_reg(gpcn_pkg::OFF_PU_LO, r16() & m_dir);
            ext_val <= r16();
            ext_drv <= ~oe_e();
            repeat (8) @(posedge clk);
            mk = IMPL & (m_ana | ~ANA_M);
            #1 chk("pad_oe", pad_oe & IMPL, oe_e());
            chk("pad_out", pad_out & oe_e(), src_e() & oe_e());
            chk("pad_out od", pad_out & m_odc, 16'h0);
            chk("periph_in", periph_in & mk, lvl_e() & mk & ~(IMPL & ~pdrv & ~m_dir));
            chk("adc_conn", adc_conn, ANA_M & IMPL & ~m_ana);
            chk("pullup_en", pullup_en, m_pu);
            rd_chk(gpcn_pkg::OFF_PIN);
        end
        $display("test pins done");
        // change pulses only from enabled pins, one per toggle
        @(posedge clk);
        cn_in <= 21'(rnd());
        repeat (8) @(posedge clk);
        foreach (bits[j]) begin
            wr_reg(gpcn_pkg::OFF_CNEN_LO, 16'(21'h1 << bits[j]));
            wr_reg(gpcn_pkg::OFF_CNEN_HI, 16'((21'h1 << bits[j]) >> 16));
            cn_in <= cn_in ^ (21'h1 << bits[j]);
            cnt_irq(1);
            cn_in <= cn_in ^ (21'h1 << ((bits[j] + 1) % 21));
            cnt_irq(0);
        end
        $display("test change done");
        // second reset in mid-run
        pdrv <= 16'h0;
        do_reset();
        rd_chk(gpcn_pkg::OFF_DIR);
        rd_chk(gpcn_pkg::OFF_CNEN_HI);
        chk("pad_oe", pad_oe, 16'h0000);
        chk("pullup_en", pullup_en, 21'h0);
        $display("test rereset done");
        close_out();
    end
endmodule : test_gpcn_port
